// ===== hdl/pin_sync.sv
`default_nettype none
module pin_sync
(
	input  wire logic mclk,   // system clock
	input  wire logic srst,   // synchronous reset
	input  wire logic ce,     // clock enable
	input  wire logic pinIn,  // asynchronous pin
	output logic      level,  // synchronised level
	output logic      rise,   // one-cycle rising edge
	output logic      fall    // one-cycle falling edge
);
	logic [1:0] syncQ;
	logic       prevQ;

	// two flops, then one more for edge history; only syncQ[1] is looked at
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			syncQ <= 2'h0;
			prevQ <= 1'b0;
		end
		else if (ce)
		begin
			syncQ <= {syncQ[0], pinIn};
			prevQ <= syncQ[1];
		end
	end

	// edges are one to two cycles late against the pin
	assign level = syncQ[1];
	assign rise  = syncQ[1] && !prevQ;
	assign fall  = !syncQ[1] && prevQ;
endmodule // pin_sync
`default_nettype wire

// ===== hdl/std_timer.sv
// Operation
// [RQ1] 16-bit up counter steps on each selected clock tick while on and unpaused.
// [RQ2] Comparator P matches period byte to count[15:8]; comparator A matches full count.
// [RQ3] Software cannot load the count; only a timer_on rise clears it. The code also clears it on overflow or a selected match.
// [RQ4] Overflow or selected match clears the count and raises a flag.
// [RQ5] Pause holds the count; clearing pause resumes from the held value.
// [RQ6] Clock select picks sys/4, sys, h/16, h/64, time-base, pin rise or fall.
// [RQ7] Timer off stops counting and keeps the value; turning on clears it.
// [RQ8] Compare mode: timer_on rise restores output to the output control level.
// [RQ9] Mode field picks compare, capture, PWM/pulse or timer; timer mode disables pin.
// [RQ10] Software should switch the timer off before changing the mode.
// [RQ11] Compare mode A match: keep, drive low, drive high or toggle output.
// [RQ12] PWM mode function: force inactive, force active, PWM, single pulse.
// [RQ13] Capture mode function: rising, falling, both edges, or capture disabled.
// [RQ14] Requested level equal to current level shows no change on match.
// [RQ15] Software must change the output function only with PWM timer off.
// [RQ16] Output control bit: initial level in compare, active level in PWM.
// [RQ17] Polarity bit inverts the output pin; no effect in timer mode.
// [RQ18] Period/duty select swaps which comparator sets PWM period and duty.
// [RQ19] Clear select: A match clears, else P match or overflow at period zero.
// [RQ20] Clear select only applies in compare and timer modes.
// [RQ21] Count readable through read-only bytes; compare A read/write byte pair.
// [RQ22] Low bytes go through an 8-bit buffer moved on high byte access.
// [RQ23] Compare mode with clear select high never raises the P flag.
// [RQ24] External clock pin is synchronised and edge detected before counting.
`default_nettype none
module std_timer
(
	input  wire logic              mclk,       // 250 MHz system clock
	input  wire logic              srst,       // synchronous reset, high
	input  wire logic              ce,         // clock enable, freezes all state
	input  wire tmr_pkg::axi_req_t axiReq,     // AXI4-Lite master to slave
	output tmr_pkg::axi_rsp_t      axiRsp,     // AXI4-Lite slave to master
	input  wire logic              hTick,      // high clock tick strobe
	input  wire logic              tbcTick,    // time-base tick strobe
	input  wire logic              extClkPin,  // external_clock_pin, async
	input  wire logic              capPin,     // capture input pin, async
	output logic                   tmrOut,     // timer output pin level
	output logic                   tmrOutEn,   // timer output pin enable
	output logic                   cmpAFlag,   // compare_a_flag pulse
	output logic                   cmpPFlag    // compare_p_flag pulse
);
	import tmr_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	ctrl0_t      ctrl0Q;
	ctrl1_t      ctrl1Q;
	logic [15:0] countQ;
	logic [15:0] countD;
	logic [15:0] cmpAQ;
	logic [7:0]  periodQ;
	logic [7:0]  byteBufQ;
	logic        onPrevQ;
	logic        lvlQ;
	logic        lvlD;
	logic        pulseQ;
	logic        flagAQ;
	logic        flagPQ;
	logic        outQ;
	logic        outEnQ;
	logic        bvalidQ;
	logic [1:0]  brespQ;
	logic        rvalidQ;
	logic [1:0]  rrespQ;
	logic [7:0]  rdataQ;

	// ---------------------------------------------------------------
	// clock sources
	// ---------------------------------------------------------------
	logic sys4Tick;
	logic h16Tick;
	logic h64Tick;
	logic extRise;
	logic extFall;
	logic capRise;
	logic capFall;

	tick_div #(.DIV(SYS_DIV)) sysDiv (
		.mclk(mclk), .srst(srst), .ce(ce), .tickIn(1'b1), .tickOut(sys4Tick));
	tick_div #(.DIV(H_DIV_LO)) hDivLo (
		.mclk(mclk), .srst(srst), .ce(ce), .tickIn(hTick), .tickOut(h16Tick));
	tick_div #(.DIV(H_DIV_HI)) hDivHi (
		.mclk(mclk), .srst(srst), .ce(ce), .tickIn(hTick), .tickOut(h64Tick));
	// pin clock goes through two flops before its edge is used
	pin_sync extSync ( // [RQ24]
		.mclk(mclk), .srst(srst), .ce(ce), .pinIn(extClkPin), .level(), .rise(extRise), .fall(extFall));
	pin_sync capSync (
		.mclk(mclk), .srst(srst), .ce(ce), .pinIn(capPin), .level(), .rise(capRise), .fall(capFall));

	// tick picked by clock_select; both time-base codes share one source
	wire [7:0] tickVec = {extFall, extRise, tbcTick, tbcTick, h64Tick, h16Tick, 1'b1, sys4Tick}; // [RQ6]
	wire       selTick = tickVec[ctrl0Q.clkSel]; // [RQ6]

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	wire              wrFire  = ce && axiReq.awvalid && axiReq.wvalid && !bvalidQ;
	wire              wrByte  = wrFire && axiReq.wstrb[0];
	wire [ADDR_W-1:0] wAddr   = axiReq.awaddr;
	wire [7:0]        wByte   = axiReq.wdata[7:0];
	wire              wrCtrl0 = wrByte && (wAddr == ADDR_CTRL0);
	wire              wrCtrl1 = wrByte && (wAddr == ADDR_CTRL1);
	wire              wrCmpAL = wrByte && (wAddr == ADDR_CMPAL);
	wire              wrCmpAH = wrByte && (wAddr == ADDR_CMPAH);
	wire              wrPer   = wrByte && (wAddr == ADDR_PER);
	// count bytes accept a write as a mapped no-op, so software cannot load them
	wire              wrHit   = (wAddr == ADDR_CTRL0) || (wAddr == ADDR_CTRL1) || (wAddr == ADDR_CNTL)
	                         || (wAddr == ADDR_CNTH) || (wAddr == ADDR_CMPAL) || (wAddr == ADDR_CMPAH)
	                         || (wAddr == ADDR_PER); // [RQ3]

	wire              rdFire  = ce && axiReq.arvalid && !rvalidQ;
	wire [ADDR_W-1:0] rAddr   = axiReq.araddr;
	wire              rdCntH  = rdFire && (rAddr == ADDR_CNTH);
	wire              rdCmpAH = rdFire && (rAddr == ADDR_CMPAH);
	// low bytes always come from the shared buffer
	wire [7:0]        rdByte  = (rAddr == ADDR_CTRL0) ? ctrl0Q :
	                            (rAddr == ADDR_CTRL1) ? ctrl1Q :
	                            (rAddr == ADDR_CNTH)  ? countQ[15:8] :
	                            (rAddr == ADDR_CMPAH) ? cmpAQ[15:8] :
	                            (rAddr == ADDR_PER)   ? periodQ :
	                            ((rAddr == ADDR_CNTL) || (rAddr == ADDR_CMPAL)) ? byteBufQ : 8'h00; // [RQ21]
	wire              rdHit   = (rAddr == ADDR_CTRL0) || (rAddr == ADDR_CTRL1) || (rAddr == ADDR_CNTL)
	                         || (rAddr == ADDR_CNTH) || (rAddr == ADDR_CMPAL) || (rAddr == ADDR_CMPAH)
	                         || (rAddr == ADDR_PER);

	// address and data are only taken together; a lone one waits
	assign axiRsp.awready = wrFire;
	assign axiRsp.wready  = wrFire;
	assign axiRsp.bvalid  = bvalidQ;
	assign axiRsp.bresp   = brespQ;
	assign axiRsp.arready = rdFire;
	assign axiRsp.rvalid  = rvalidQ;
	assign axiRsp.rdata   = {24'h000000, rdataQ};
	assign axiRsp.rresp   = rrespQ;

	// ---------------------------------------------------------------
	// counter and comparators
	// ---------------------------------------------------------------
	wire        modeCmp  = (ctrl1Q.mode == MODE_CMP);
	wire        modeCap  = (ctrl1Q.mode == MODE_CAP);
	wire        modePwm  = (ctrl1Q.mode == MODE_PWM);
	wire        modeTmr  = (ctrl1Q.mode == MODE_TMR);
	wire        cmpLike  = modeCmp || modeTmr;
	wire        onRise   = ctrl0Q.on && !onPrevQ; // [RQ3]
	wire        step     = ce && ctrl0Q.on && !ctrl0Q.pause && selTick && !onRise; // [RQ1] [RQ5] [RQ7]
	wire [15:0] countInc = countQ + 16'h0001; // [RQ1]
	// matches look at the value the step would produce, so a period of N ticks clears after N
	wire        matchA   = step && (countInc == cmpAQ); // [RQ2]
	// period zero matches at the wrap to zero, which is the overflow case
	wire        matchP   = step && (countInc[15:8] == periodQ) && (countInc[7:0] == 8'h00); // [RQ2] [RQ19]
	wire        pwmClr   = ctrl1Q.perDuty ? matchA : matchP; // [RQ18]
	wire        clrHit   = cmpLike ? (ctrl1Q.clrSel ? matchA : matchP) : (modePwm && pwmClr); // [RQ19] [RQ20] [RQ4]
	wire        capEdge  = (ctrl1Q.outFn == CAP_RISE) ? capRise :
	                       (ctrl1Q.outFn == CAP_FALL) ? capFall :
	                       (ctrl1Q.outFn == CAP_BOTH) ? (capRise || capFall) : 1'b0; // [RQ13]
	wire        capEvent = ce && modeCap && ctrl0Q.on && capEdge; // [RQ13]
	wire        flagAEv  = modeCap ? capEvent : matchA; // [RQ4]
	wire        flagPEv  = matchP && !(cmpLike && ctrl1Q.clrSel); // [RQ23]

	assign countD = onRise ? CNT_RST : clrHit ? CNT_RST : step ? countInc : countQ; // [RQ3] [RQ4] [RQ7]

	// ---------------------------------------------------------------
	// output shaping
	// ---------------------------------------------------------------
	wire       fnLevel  = (ctrl1Q.outFn == FN_LOW)    ? 1'b0 :
	                      (ctrl1Q.outFn == FN_HIGH)   ? 1'b1 :
	                      (ctrl1Q.outFn == FN_TOGGLE) ? !lvlQ : lvlQ; // [RQ11] [RQ14]
	wire       dutyEnd  = ctrl1Q.perDuty ? matchP : matchA;
	// duty at or above the period simply stays active all period long
	wire       dutyAct  = ctrl1Q.perDuty ? ((periodQ == 8'h00) || (countQ[15:8] < periodQ))
	                                     : (countQ < cmpAQ); // [RQ18]
	wire       pwmAct   = (ctrl1Q.outFn == FN_INACT) ? 1'b0 :
	                      (ctrl1Q.outFn == FN_ACT)   ? 1'b1 :
	                      (ctrl1Q.outFn == FN_PWM)   ? dutyAct : pulseQ; // [RQ12]
	wire       pwmLevel = pwmAct ? ctrl1Q.outCtl : !ctrl1Q.outCtl; // [RQ16]
	wire       pinLevel = modePwm ? pwmLevel : lvlQ;

	assign lvlD = (modeCmp && onRise) ? ctrl1Q.outCtl :
	              (modeCmp && matchA) ? fnLevel : lvlQ; // [RQ8] [RQ16] [RQ11]

	assign tmrOut   = outQ;
	assign tmrOutEn = outEnQ;
	assign cmpAFlag = flagAQ;
	assign cmpPFlag = flagPQ;

	// ---------------------------------------------------------------
	// registers written by software
	// ---------------------------------------------------------------
	// reserved control bits are dropped on write so they read back as zero
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			ctrl0Q  <= CTRL0_RST;
			ctrl1Q  <= CTRL1_RST;
			periodQ <= PER_RST;
		end
		else
		begin
			if (wrCtrl0)
				ctrl0Q <= {wByte[7:3], 3'h0};
			if (wrCtrl1)
				ctrl1Q <= wByte;
			if (wrPer)
				periodQ <= wByte;
		end
	end

	// shared low-byte buffer; a same-cycle low write beats a high-read latch
	always_ff @(posedge mclk)
	begin
		if (srst)
			byteBufQ <= BUF_RST;
		else if (wrCmpAL)
			byteBufQ <= wByte; // [RQ22]
		else if (rdCntH)
			byteBufQ <= countQ[7:0]; // [RQ22]
		else if (rdCmpAH)
			byteBufQ <= cmpAQ[7:0]; // [RQ22]
	end

	// compare A takes both bytes at once; a capture wins over a bus write
	always_ff @(posedge mclk)
	begin
		if (srst)
			cmpAQ <= CMPA_RST;
		else if (capEvent)
			cmpAQ <= countQ; // [RQ13]
		else if (wrCmpAH)
			cmpAQ <= {wByte, byteBufQ}; // [RQ22] [RQ21]
	end

	// ---------------------------------------------------------------
	// timer state
	// ---------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			countQ  <= CNT_RST;
			onPrevQ <= 1'b0;
			lvlQ    <= 1'b0;
			flagAQ  <= 1'b0;
			flagPQ  <= 1'b0;
		end
		else if (ce)
		begin
			countQ  <= countD;
			onPrevQ <= ctrl0Q.on;
			lvlQ    <= lvlD;
			flagAQ  <= flagAEv;
			flagPQ  <= flagPEv;
		end
	end

	// single pulse: armed by timer_on rising, ended by the duty match
	always_ff @(posedge mclk)
	begin
		if (srst)
			pulseQ <= 1'b0;
		else if (ce && onRise)
			pulseQ <= modePwm && (ctrl1Q.outFn == FN_PULSE); // [RQ12]
		else if (ce && dutyEnd)
			pulseQ <= 1'b0; // [RQ12]
	end

	// pin registered; released in timer and capture modes
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			outQ   <= 1'b0;
			outEnQ <= 1'b0;
		end
		else if (ce)
		begin
			outQ   <= modeTmr ? 1'b0 : (pinLevel ^ ctrl1Q.outPol); // [RQ17]
			outEnQ <= modeCmp || modePwm; // [RQ9]
		end
	end

	// ---------------------------------------------------------------
	// bus answers
	// ---------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			bvalidQ <= 1'b0;
			brespQ  <= RESP_OKAY;
			rvalidQ <= 1'b0;
			rrespQ  <= RESP_OKAY;
			rdataQ  <= 8'h00;
		end
		else if (ce)
		begin
			if (wrFire)
			begin
				bvalidQ <= 1'b1;
				brespQ  <= wrHit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (axiReq.bready)
				bvalidQ <= 1'b0;
			if (rdFire)
			begin
				rvalidQ <= 1'b1;
				rrespQ  <= rdHit ? RESP_OKAY : RESP_SLVERR;
				rdataQ  <= rdByte;
			end
			else if (axiReq.rready)
				rvalidQ <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_countStep;
		@(posedge mclk) disable iff (srst)
		(step && !clrHit) |=> (countQ == $past(countInc));
	endproperty
	a_countStep: assert property (p_countStep) else $error("count did not advance by one"); // [RQ1]

	property p_pauseHold;
		@(posedge mclk) disable iff (srst)
		(ctrl0Q.pause && ctrl0Q.on && onPrevQ) |=> $stable(countQ);
	endproperty
	a_pauseHold: assert property (p_pauseHold) else $error("count moved while paused"); // [RQ5]

	property p_onClear;
		@(posedge mclk) disable iff (srst)
		(ce && onRise) |=> (countQ == 16'h0000) && !onRise;
	endproperty
	a_onClear: assert property (p_onClear) else $error("count not cleared by timer_on rise"); // [RQ7]

	property p_offHold;
		@(posedge mclk) disable iff (srst)
		(!ctrl0Q.on) [*2] |-> $stable(countQ);
	endproperty
	a_offHold: assert property (p_offHold) else $error("count moved while off"); // [RQ3]

	property p_noPFlag;
		@(posedge mclk) disable iff (srst)
		(ce && modeCmp && ctrl1Q.clrSel) |=> !cmpPFlag;
	endproperty
	a_noPFlag: assert property (p_noPFlag) else $error("P flag raised with clear on A"); // [RQ23]

	property p_clearOnA;
		@(posedge mclk) disable iff (srst)
		(cmpLike && ctrl1Q.clrSel && matchA) |=> (countQ == 16'h0000) && cmpAFlag;
	endproperty
	a_clearOnA: assert property (p_clearOnA) else $error("A match did not clear and flag"); // [RQ19]

	property p_outHigh;
		@(posedge mclk) disable iff (srst)
		(modeCmp && matchA && !onRise && (ctrl1Q.outFn == FN_HIGH)) |=> lvlQ;
	endproperty
	a_outHigh: assert property (p_outHigh) else $error("output not driven high on A match"); // [RQ11]

	property p_initLevel;
		@(posedge mclk) disable iff (srst)
		(ce && modeCmp && onRise && !wrCtrl1) |=> (lvlQ == $past(ctrl1Q.outCtl));
	endproperty
	a_initLevel: assert property (p_initLevel) else $error("output not at initial level"); // [RQ8]

	property p_pinPolarity;
		@(posedge mclk) disable iff (srst)
		(ce && modeCmp && !wrCtrl1) |=> (tmrOut == ($past(lvlQ) ^ ctrl1Q.outPol));
	endproperty
	a_pinPolarity: assert property (p_pinPolarity) else $error("pin polarity wrong"); // [RQ17]

	property p_timerNoPin;
		@(posedge mclk) disable iff (srst)
		(ce && modeTmr && !wrCtrl1) |=> (!tmrOutEn && !tmrOut);
	endproperty
	a_timerNoPin: assert property (p_timerNoPin) else $error("pin driven in timer mode"); // [RQ9]
endmodule // std_timer
`default_nettype wire

// ===== hdl/tick_div.sv
`default_nettype none
module tick_div
#(
	parameter int DIV = 4 // source ticks per output tick
)
(
	input  wire logic mclk,    // system clock
	input  wire logic srst,    // synchronous reset
	input  wire logic ce,      // clock enable
	input  wire logic tickIn,  // source tick
	output logic      tickOut  // divided tick, one cycle
);
	localparam int            CW   = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cntQ;

	// output fires on the last source tick of each group
	assign tickOut = tickIn && (cntQ == LAST);

	// counts source ticks only, so the ratio holds for a sparse source
	always_ff @(posedge mclk)
	begin
		if (srst)
			cntQ <= '0;
		else if (ce && tickIn)
			cntQ <= tickOut ? '0 : cntQ + 1'b1;
	end
endmodule // tick_div
`default_nettype wire

// ===== hdl/tmr_pkg.sv
`default_nettype none
package tmr_pkg;
	// ---------------------------------------------------------------
	// register map, byte addresses on the AXI4-Lite port
	// ---------------------------------------------------------------
	localparam int              ADDR_W      = 5;
	localparam logic [ADDR_W-1:0] ADDR_CTRL0 = 5'h00; // timer_control_0
	localparam logic [ADDR_W-1:0] ADDR_CTRL1 = 5'h04; // timer_control_1
	localparam logic [ADDR_W-1:0] ADDR_CNTL  = 5'h08; // count_low_byte
	localparam logic [ADDR_W-1:0] ADDR_CNTH  = 5'h0c; // count_high_byte
	localparam logic [ADDR_W-1:0] ADDR_CMPAL = 5'h10; // compare_a_low_byte
	localparam logic [ADDR_W-1:0] ADDR_CMPAH = 5'h14; // compare_a_high_byte
	localparam logic [ADDR_W-1:0] ADDR_PER   = 5'h18; // period_compare_byte

	// ---------------------------------------------------------------
	// reset values and bus answers
	// ---------------------------------------------------------------
	localparam logic [7:0]  CTRL0_RST   = 8'h00;
	localparam logic [7:0]  CTRL1_RST   = 8'h00;
	localparam logic [15:0] CNT_RST     = 16'h0000;
	localparam logic [15:0] CMPA_RST    = 16'h0000;
	localparam logic [7:0]  PER_RST     = 8'h00;
	localparam logic [7:0]  BUF_RST     = 8'h00;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// prescaler ratios
	// ---------------------------------------------------------------
	localparam int SYS_DIV  = 4;
	localparam int H_DIV_LO = 16;
	localparam int H_DIV_HI = 64;

	// ---------------------------------------------------------------
	// field encodings
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		CK_SYS4 = 3'h0, CK_SYS = 3'h1, CK_H16 = 3'h2, CK_H64 = 3'h3,
		CK_TBC0 = 3'h4, CK_TBC1 = 3'h5, CK_EXT_RISE = 3'h6, CK_EXT_FALL = 3'h7
	} clk_sel_t;
	typedef enum logic [1:0] {
		MODE_CMP = 2'h0, MODE_CAP = 2'h1, MODE_PWM = 2'h2, MODE_TMR = 2'h3
	} op_mode_t;
	localparam logic [1:0] FN_NONE  = 2'h0, FN_LOW = 2'h1, FN_HIGH = 2'h2, FN_TOGGLE = 2'h3;
	localparam logic [1:0] FN_INACT = 2'h0, FN_ACT = 2'h1, FN_PWM = 2'h2, FN_PULSE = 2'h3;
	localparam logic [1:0] CAP_RISE = 2'h0, CAP_FALL = 2'h1, CAP_BOTH = 2'h2, CAP_OFF = 2'h3;

	// ---------------------------------------------------------------
	// register layouts and bus carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic       pause;   // pause_bit
		clk_sel_t   clkSel;  // clock_select
		logic       on;      // timer_on
		logic [2:0] unused;  // reads as zero
	} ctrl0_t;
	typedef struct packed {
		op_mode_t   mode;     // operating_mode_field
		logic [1:0] outFn;    // output_function_field
		logic       outCtl;   // output_control_bit
		logic       outPol;   // output_polarity
		logic       perDuty;  // period_duty_select
		logic       clrSel;   // clear_select
	} ctrl1_t;
	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} axi_req_t;
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_rsp_t;
endpackage
`default_nettype wire

// ===== tb/testbench.sv
`default_nettype none
module testbench
	import tmr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------
	// signals, clock and design
	// ------------------------------------------------
	logic        mclk, srst, ce, hTick, tbcTick, extClkPin, capPin;
	axi_req_t    req;
	axi_rsp_t    rsp;
	logic        tmrOut, tmrOutEn, cmpAFlag, cmpPFlag, prevOut;
	int          failures, n_compared, seed, gap, nA, nP, nHi;
	logic [15:0] cmpN;
	logic [31:0] expD[$];
	logic [1:0]  expR[$];
	logic [31:0] nowD;
	logic [1:0]  nowR;
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	std_timer std_timer_inst (.mclk(mclk), .srst(srst), .ce(ce), .axiReq(req), .axiRsp(rsp), .hTick(hTick),
		.tbcTick(tbcTick), .extClkPin(extClkPin), .capPin(capPin), .tmrOut(tmrOut), .tmrOutEn(tmrOutEn),
		.cmpAFlag(cmpAFlag), .cmpPFlag(cmpPFlag));
	// random high-clock strobe keeps the unused prescaler path busy
	always @(posedge mclk) hTick <= 1'($random(seed));
	// flag pulses counted at the settled half of the cycle
	always @(negedge mclk)
	begin
		if (cmpAFlag === 1'b1) nA++;
		if (cmpPFlag === 1'b1) nP++;
	end
	// read answers taken off the note queue as each one is accepted;
	// both notes are popped first so a data mismatch cannot skew the queues
	always @(negedge mclk)
		if (rsp.rvalid === 1'b1 && req.rready === 1'b1)
		begin
			nowD = expD.pop_front();
			nowR = expR.pop_front();
			chk(rsp.rdata === nowD && rsp.rresp === nowR, "read data");
		end
	// ------------------------------------------------
	// tasks
	// ------------------------------------------------
	task automatic chk(input logic ok, input string msg);
		n_compared++;
		if (ok !== 1'b1)
		begin
			failures++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	// handshakes sampled at the falling edge so the next rising edge is not raced
	task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge mclk);
		req.awvalid <= 1'b1;
		req.wvalid  <= 1'b1;
		req.awaddr  <= a;
		req.wdata   <= {24'h000000, d};
		req.wstrb   <= 4'h1;
		req.bready  <= 1'b1;
		do @(negedge mclk); while (rsp.awready !== 1'b1);
		@(posedge mclk);
		req.awvalid <= 1'b0;
		req.wvalid  <= 1'b0;
		do @(negedge mclk); while (rsp.bvalid !== 1'b1);
		chk(rsp.bresp === er, "write response");
		@(posedge mclk);
		req.bready <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
		expD.push_back({24'h000000, d});
		expR.push_back(er);
		@(posedge mclk);
		req.arvalid <= 1'b1;
		req.araddr  <= a;
		req.rready  <= 1'b1;
		do @(negedge mclk); while (rsp.arready !== 1'b1);
		@(posedge mclk);
		req.arvalid <= 1'b0;
		do @(negedge mclk); while (rsp.rvalid !== 1'b1);
		@(posedge mclk);
		req.rready <= 1'b0;
	endtask
	// cycles up to and including the next A pulse, bounded
	task automatic waitA();
		gap = 0;
		do
		begin
			@(negedge mclk);
			gap++;
		end
		while (cmpAFlag !== 1'b1 && gap < 300);
	endtask
	task automatic complete_run();
		$display("compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------
	initial
	begin
		seed = 32'h67bba093;
		req = '0;
		{ce, srst, tbcTick, extClkPin, capPin} = 5'h18;
		cmpN = 16'h0008 + 16'($random(seed) & 15);
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		for (int i = 0; i < 7; i++) rd(5'(i * 4), 8'h00, RESP_OKAY);
		rd(5'h1c, 8'h00, RESP_SLVERR);
		wr(5'h1c, 8'h5a, RESP_SLVERR);
		wr(ADDR_CNTH, 8'hff, RESP_OKAY);
		rd(ADDR_CNTH, 8'h00, RESP_OKAY);
		wr(ADDR_CMPAL, cmpN[7:0], RESP_OKAY);
		rd(ADDR_CMPAH, 8'h00, RESP_OKAY);
		rd(ADDR_CMPAL, 8'h00, RESP_OKAY);
		wr(ADDR_CMPAL, cmpN[7:0], RESP_OKAY);
		wr(ADDR_CMPAH, cmpN[15:8], RESP_OKAY);
		rd(ADDR_CMPAH, cmpN[15:8], RESP_OKAY);
		rd(ADDR_CMPAL, cmpN[7:0], RESP_OKAY);
		$display("register test done");
		wr(ADDR_CTRL1, 8'h31, RESP_OKAY);
		wr(ADDR_CTRL0, 8'h18, RESP_OKAY);
		waitA();
		prevOut = tmrOut;
		nP = 0;
		repeat (3)
		begin
			waitA();
			chk(gap == cmpN, "match spacing");
			chk(tmrOut !== prevOut, "toggle");
			prevOut = tmrOut;
		end
		// clock enable low one edge after a match: the count must freeze mid-period
		@(posedge mclk);
		ce <= 1'b0;
		nA = 0;
		repeat (3 * cmpN) @(negedge mclk);
		chk(nA == 0, "frozen by clock enable");
		@(posedge mclk);
		ce <= 1'b1;
		waitA();
		chk(gap == cmpN, "resume after clock enable");
		chk(nP == 0 && tmrOutEn === 1'b1, "P flag or enable");
		$display("compare test done");
		wr(ADDR_CTRL0, 8'h98, RESP_OKAY);
		repeat (2) @(negedge mclk);
		nA = 0;
		repeat (3 * cmpN) @(negedge mclk);
		chk(nA == 0, "paused");
		wr(ADDR_CTRL0, 8'h18, RESP_OKAY);
		waitA();
		chk(gap <= cmpN, "resume");
		$display("pause test done");
		wr(ADDR_CTRL0, 8'h10, RESP_OKAY);
		wr(ADDR_CTRL1, 8'h21, RESP_OKAY);
		wr(ADDR_CTRL0, 8'h18, RESP_OKAY);
		waitA();
		repeat (3) @(negedge mclk);
		chk(tmrOut === 1'b1, "drive high");
		wr(ADDR_CTRL0, 8'h10, RESP_OKAY);
		wr(ADDR_CTRL0, 8'h18, RESP_OKAY);
		repeat (2) @(negedge mclk);
		chk(tmrOut === 1'b0, "initial level");
		wr(ADDR_CTRL0, 8'h10, RESP_OKAY);
		wr(ADDR_CTRL1, 8'h25, RESP_OKAY);
		repeat (3) @(negedge mclk);
		chk(tmrOut === 1'b1, "inverted");
		wr(ADDR_CTRL1, 8'hc1, RESP_OKAY);
		repeat (3) @(negedge mclk);
		chk(tmrOutEn === 1'b0 && tmrOut === 1'b0, "timer mode pin");
		$display("output test done");
		// period byte 1: P clears every 256 ticks, A fires once per period
		wr(ADDR_PER, 8'h01, RESP_OKAY);
		wr(ADDR_CTRL1, 8'hc0, RESP_OKAY);
		wr(ADDR_CTRL0, 8'h18, RESP_OKAY);
		nA = 0;
		nP = 0;
		repeat (640) @(negedge mclk);
		chk(nA == 3 && nP == 2, "period clear and both flags");
		wr(ADDR_CTRL0, 8'h10, RESP_OKAY);
		$display("period test done");
		// pin clock on rising edges only; the falls in between must not count
		wr(ADDR_CTRL1, 8'hc1, RESP_OKAY);
		wr(ADDR_CTRL0, 8'h68, RESP_OKAY);
		nA = 0;
		repeat (2 * cmpN)
		begin
			@(posedge mclk);
			extClkPin <= !extClkPin;
			repeat (3) @(posedge mclk);
		end
		repeat (8) @(negedge mclk);
		chk(nA == 1, "pin rising edges counted");
		wr(ADDR_CTRL0, 8'h60, RESP_OKAY);
		$display("pin clock test done");
		// output function changed only while off; duty of cmpN ticks in 256
		wr(ADDR_CTRL1, 8'ha8, RESP_OKAY);
		wr(ADDR_CTRL0, 8'h18, RESP_OKAY);
		repeat (8) @(negedge mclk);
		nHi = 0;
		repeat (256)
		begin
			@(negedge mclk);
			if (tmrOut === 1'b1)
				nHi++;
		end
		chk(nHi == cmpN && tmrOutEn === 1'b1, "PWM duty");
		$display("pwm test done");
		complete_run();
	end
	// a hang counts as a mismatch; the run needs under two thousand cycles
	initial
	begin
		#200000;
		failures++;
		complete_run();
	end
endmodule // testbench
`default_nettype wire
